// File: esrst_pkg.sv
/*
  Package for the ready-output self-test sequencer: states, time limits, tick divider.
  Assumes a 10 MHz system clock.
*/
package esrst_pkg;
  localparam int unsigned CLK_HZ        = 10000000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam logic [13:0] TICK_LAST     = 14'(TICK_CYCLES - 1);
  // Time limits in ms, as printed
  localparam int unsigned OFF_LIMIT_MS  = 66;
  localparam int unsigned ACK_LARGE_MS  = 114;
  localparam int unsigned ACK_SMALL_MS  = 146;
  localparam int unsigned ON_LIMIT_MS   = 20;
  // Tick counts: off and on limits round down, one tick margin taken off; ack limits kept as printed
  localparam logic [7:0]  OFF_TICKS     = 8'(OFF_LIMIT_MS - 1);
  localparam logic [7:0]  ACK_LARGE_TKS = 8'(ACK_LARGE_MS);
  localparam logic [7:0]  ACK_SMALL_TKS = 8'(ACK_SMALL_MS);
  localparam logic [7:0]  ON_TICKS      = 8'(ON_LIMIT_MS - 1);
  localparam logic [1:0]  STAGE_FIRST   = 2'h0;
  localparam logic [1:0]  STAGE_LAST    = 2'h2;
  localparam logic [7:0]  CNT_ZERO      = 8'h00;

  typedef enum logic [2:0] {
    ST_WAIT_VOLT = 3'b000,
    ST_DROP      = 3'b001,
    ST_WAIT_LOW  = 3'b010,
    ST_RAISE     = 3'b011,
    ST_FINAL     = 3'b100,
    ST_RUN       = 3'b101,
    ST_ESTOP     = 3'b110,
    ST_FAULT     = 3'b111
  } esrst_state_t;
endpackage

// File: esrst_relay_model.sv
/* Relay loop and control-voltage model.
   Assumes the bench drives its controls just after a rising edge. */
`timescale 1ns/10ps
module esrst_relay_model
(
  // System
  input wire logic        clock,
  input wire logic        sys_rst,
  // Bench controls
  input wire logic        volt_on,
  input wire logic        stuck,
  input wire logic [15:0] delay,
  // Relay loop
  input wire logic        ready_output,
  output logic            ready_ack_input
);
  logic        want;
  logic [15:0] cnt_reg;
  // Ack needs voltage and a closed ready contact; stuck welds it
  assign want = volt_on & (ready_output | stuck);
  // Delay stays far below the limit, so the answer is in time whenever stuck is low
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ready_ack_input <= 1'b0;
      cnt_reg <= 16'h0000;
    end
    else if (want == ready_ack_input)
      cnt_reg <= 16'h0000;
    else if (cnt_reg >= delay)
    begin
      ready_ack_input <= want;
      cnt_reg <= 16'h0000;
    end
    else
      cnt_reg <= cnt_reg + 16'h0001;
  end
endmodule // esrst_relay_model

// File: esrst_seq.sv
/*
  Power-on self-test and supervision sequencer for the ready output.
  Assumes ready_ack_input comes from external relay logic (asynchronous),
  and internal_fault, error_cancel come from logic on the same clock.
*/
`timescale 1ns/10ps
module esrst_seq
#(
  // Cycles per millisecond tick
  parameter int unsigned TICK_LEN = esrst_pkg::TICK_CYCLES
)
(
  // System
  input  wire logic clock,
  input  wire logic sys_rst,
  // Variant: 1 selects the smaller control with longer acknowledge limit
  input  wire logic small_variant,
  // Relay side
  input  wire logic ready_ack_input,
  output logic      ready_output,
  // Internal supervision
  input  wire logic internal_fault,
  input  wire logic error_cancel,
  // Status
  output logic      volt_missing,
  output logic      stop_defective,
  output logic      estop_shown,
  output logic      cancellable_error_flag,
  output logic      external_stop_shown_flag,
  output logic      fault_flash,
  output logic      plc_halt,
  output logic      normal_run,
  output logic [1:0] stage
);
  esrst_tick_if tkif ();

  esrst_tick
  #(
    .TICK_LEN (TICK_LEN)
  )
  u_tick
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tk      (tkif.src)
  );

  typedef struct packed
  {
    logic [2:0]              sync;
    logic                    ack;
    esrst_pkg::esrst_state_t st;
    logic [1:0]              stage;
    logic [7:0]              cnt;
    logic [7:0]              drop_ms;
    logic                    rdy;
    logic                    defective;
    logic                    canc;
    logic                    ext;
    logic                    flash;
  } esrst_seq_st_t;

  esrst_seq_st_t s_reg;
  esrst_seq_st_t s_next;
  logic [7:0]    ack_lim;
  logic          tick;

  assign tick    = tkif.tick;
  // Larger control 114 ms, smaller 146 ms
  assign ack_lim = small_variant ? esrst_pkg::ACK_SMALL_TKS : esrst_pkg::ACK_LARGE_TKS;

  always_comb
  begin
    s_next      = s_reg;
    // Ack filtered: change only once stages two and three agree
    s_next.sync = {s_reg.sync[1:0], ready_ack_input};
    if (s_reg.sync[2] == s_reg.sync[1])
      s_next.ack = s_reg.sync[2];
    if (tick)
      s_next.cnt = s_reg.cnt + 8'h01;
    // Ticks spent before the drop; only the assertion reads it
    if (s_reg.st != esrst_pkg::ST_DROP)
      s_next.drop_ms = esrst_pkg::CNT_ZERO;
    else if (tick)
      s_next.drop_ms = s_reg.drop_ms + 8'h01;
    // Fault wins over everything and sticks until reset
    if (internal_fault && s_reg.st != esrst_pkg::ST_FAULT)
    begin
      s_next.st    = esrst_pkg::ST_FAULT;
      s_next.rdy   = 1'b0;
      s_next.flash = 1'b1;
    end
    else
    begin
      case (s_reg.st)
        esrst_pkg::ST_WAIT_VOLT:
        begin
          s_next.cnt = esrst_pkg::CNT_ZERO;
          if (s_reg.ack)
            s_next.st = esrst_pkg::ST_DROP;
        end
        esrst_pkg::ST_DROP:
        begin
          // Drop well inside the limit: off at the next ms tick, at most one ms
          if (s_reg.cnt != esrst_pkg::CNT_ZERO || tick)
          begin
            s_next.rdy = 1'b0;
            s_next.cnt = esrst_pkg::CNT_ZERO;
            s_next.st  = esrst_pkg::ST_WAIT_LOW;
          end
        end
        esrst_pkg::ST_WAIT_LOW:
        begin
          if (!s_reg.ack)
          begin
            s_next.cnt = esrst_pkg::CNT_ZERO;
            s_next.st  = esrst_pkg::ST_RAISE;
          end
          else if (s_reg.cnt >= ack_lim)
          begin
            s_next.defective = 1'b1;
            s_next.st        = esrst_pkg::ST_FAULT;
          end
        end
        esrst_pkg::ST_RAISE:
        begin
          s_next.rdy = 1'b1;
          s_next.cnt = esrst_pkg::CNT_ZERO;
          if (s_reg.stage == esrst_pkg::STAGE_LAST)
            s_next.st = esrst_pkg::ST_FINAL;
          else
          begin
            s_next.stage = s_reg.stage + 2'h1;
            s_next.st    = esrst_pkg::ST_WAIT_VOLT;
          end
        end
        esrst_pkg::ST_FINAL:
        begin
          if (s_reg.ack)
            s_next.st = esrst_pkg::ST_RUN;
        end
        esrst_pkg::ST_RUN:
        begin
          if (!s_reg.ack)
          begin
            s_next.st   = esrst_pkg::ST_ESTOP;
            s_next.canc = 1'b1;
            s_next.ext  = 1'b1;
          end
        end
        esrst_pkg::ST_ESTOP:
        begin
          if (error_cancel && s_reg.ack)
          begin
            s_next.st   = esrst_pkg::ST_RUN;
            s_next.canc = 1'b0;
            s_next.ext  = 1'b0;
          end
        end
        esrst_pkg::ST_FAULT:
        begin
          s_next.rdy = 1'b0;
          s_next.cnt = esrst_pkg::CNT_ZERO;
        end
        default:
          s_next.st = esrst_pkg::ST_FAULT;
      endcase
    end
  end

  // Ready output starts high so the first drop is a real change
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_reg       <= '0;
      s_reg.rdy   <= 1'b1;
      s_reg.stage <= esrst_pkg::STAGE_FIRST;
    end
    else
      s_reg <= s_next;
  end

  assign ready_output             = s_reg.rdy;
  assign volt_missing             = (s_reg.st == esrst_pkg::ST_WAIT_VOLT ||
                                     s_reg.st == esrst_pkg::ST_FINAL) && !s_reg.ack;
  assign stop_defective           = s_reg.defective;
  assign estop_shown              = s_reg.ext;
  assign cancellable_error_flag   = s_reg.canc;
  assign external_stop_shown_flag = s_reg.ext;
  assign fault_flash              = s_reg.flash;
  assign plc_halt                 = (s_reg.st == esrst_pkg::ST_FAULT);
  assign normal_run               = (s_reg.st == esrst_pkg::ST_RUN);
  assign stage                    = s_reg.stage;

  sequence seq_drop_seen;
    s_reg.st == esrst_pkg::ST_DROP;
  endsequence

  sequence seq_ready_low;
    !ready_output;
  endsequence

  // Limit counted in ticks: a cycle range this long would choke the tools
  AST_DROP_IN_TIME: assert property (@(posedge clock) disable iff (sys_rst)
    seq_drop_seen |-> s_reg.drop_ms < esrst_pkg::OFF_TICKS)
    else $error("Ready output not dropped in time");

  AST_DROP_ON_TICK: assert property (@(posedge clock) disable iff (sys_rst)
    (seq_drop_seen ##0 tick) |=> seq_ready_low)
    else $error("Ready output still high after drop tick");

  AST_RAISE_AFTER_LOW: assert property (@(posedge clock) disable iff (sys_rst)
    (s_reg.st == esrst_pkg::ST_WAIT_LOW && !s_reg.ack) |-> ##2 ready_output)
    else $error("Ready output not raised after ack fell");

  AST_DEFECT_FAULT: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(stop_defective) |-> plc_halt && !ready_output)
    else $error("Defective without fault state");

  AST_FAULT_OFF: assert property (@(posedge clock) disable iff (sys_rst)
    (internal_fault && !plc_halt) |=> (plc_halt && fault_flash && !ready_output))
    else $error("Fault did not drop ready output");

  AST_FAULT_STICKS: assert property (@(posedge clock) disable iff (sys_rst)
    plc_halt |=> plc_halt)
    else $error("Fault state left without reset");

  AST_ESTOP_FLAGS: assert property (@(posedge clock) disable iff (sys_rst)
    (normal_run && !s_reg.ack) |=> (cancellable_error_flag && external_stop_shown_flag))
    else $error("Emergency stop flags not set");

  AST_CLEAR_NEEDS_VOLT: assert property (@(posedge clock) disable iff (sys_rst)
    (s_reg.st == esrst_pkg::ST_ESTOP && !s_reg.ack) |=> !normal_run)
    else $error("Stop cleared without voltage");

  AST_RUN_HIGH: assert property (@(posedge clock) disable iff (sys_rst)
    normal_run |-> ready_output && stage == esrst_pkg::STAGE_LAST)
    else $error("Run without ready high");

  AST_STAGE_ORDER: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(stage) |-> stage == $past(stage) + 2'h1)
    else $error("Stage skipped");

  AST_VOLT_MISSING: assert property (@(posedge clock) disable iff (sys_rst)
    (s_reg.st == esrst_pkg::ST_WAIT_VOLT && !s_reg.ack) |-> volt_missing)
    else $error("Voltage missing not reported");
endmodule // esrst_seq

// File: esrst_tick.sv
/*
  Millisecond tick divider: one-cycle enable pulse every 1 ms.
  Assumes a 10 MHz clock and asynchronous active-high reset.
*/
`timescale 1ns/10ps
module esrst_tick
#(
  // Cycles per tick; a bench may shorten it to keep runs brief
  parameter int unsigned TICK_LEN = esrst_pkg::TICK_CYCLES
)
(
  // System
  input wire logic   clock,
  input wire logic   sys_rst,
  // Tick out
  esrst_tick_if.src  tk
);
  typedef struct packed
  {
    logic [13:0] cnt;
    logic        tick;
  } esrst_tick_st_t;

  localparam logic [13:0] TICK_END = 14'(TICK_LEN - 1);

  esrst_tick_st_t s_reg;
  esrst_tick_st_t s_next;

  always_comb
  begin
    s_next      = s_reg;
    s_next.tick = (s_reg.cnt == TICK_END);
    s_next.cnt  = s_next.tick ? 14'h0000 : s_reg.cnt + 14'h0001;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign tk.tick = s_reg.tick;
endmodule // esrst_tick

// File: esrst_tick_if.sv
/*
  Interface carrying the millisecond tick between the divider and the sequencer.
  Assumes both ends share the system clock.
*/
`timescale 1ns/10ps
interface esrst_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface // esrst_tick_if

// File: estop_ready_self_test_tb.sv
/* Self-checking bench for the ready-output self-test sequencer.
   Assumes the relay model stands on the far side. */
`timescale 1ns/10ps
module estop_ready_self_test_tb;
  logic        clock, sys_rst, small_variant, internal_fault, error_cancel;
  logic        volt_on, stuck, ack, rdy, vm, sdef, esh, cef, xsf, ffl, halt, run;
  logic [15:0] delay;
  logic [1:0]  stage;
  logic [2:0]  e;
  logic [2:0]  exp_q[$];
  int          fails, checks_done, seed;
  time         t_up, t_dn, t_fall;
  // Short tick keeps the run brief: one scaled ms is 100 cycles
  localparam int unsigned TICK  = 100;
  localparam time         MS_NS = 64'd10000;

  esrst_seq #(.TICK_LEN(TICK)) dut (.clock(clock), .sys_rst(sys_rst),
    .small_variant(small_variant),
    .ready_ack_input(ack), .ready_output(rdy), .internal_fault(internal_fault),
    .error_cancel(error_cancel), .volt_missing(vm), .stop_defective(sdef),
    .estop_shown(esh), .cancellable_error_flag(cef), .external_stop_shown_flag(xsf),
    .fault_flash(ffl), .plc_halt(halt), .normal_run(run), .stage(stage));
  esrst_relay_model relay (.clock(clock), .sys_rst(sys_rst), .volt_on(volt_on),
    .stuck(stuck), .delay(delay), .ready_output(rdy), .ready_ack_input(ack));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] ex);
    checks_done++;
    if (seen !== ex)
    begin
      fails++;
      $display("FAIL %s expected %0h seen %0h", what, ex, seen);
    end
  endtask

  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Bounded wait; running out counts as a mismatch
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1)
    begin
      @(posedge clock);
      #1;
      n++;
      if (n > lim)
      begin
        check("wait", s, 1);
        give_verdict();
      end
    end
  endtask

  task automatic pulse_cancel;
    cyc(1);
    error_cancel <= 1'b1;
    cyc(1);
    error_cancel <= 1'b0;
    cyc(100);
    #1;
  endtask

  always @(posedge ack) t_up = $time;
  always @(negedge ack) t_dn = $time;
  always @(negedge rdy) t_fall = $time;

  // Each ready change out of reset takes the oldest note; a drop note with stage 3 is not timed
  always
  begin
    @(rdy);
    #1;
    if (!sys_rst && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check("ready_output", rdy, e[2]);
      if (!e[2] && e[1:0] != 2'h3)
      begin
        check("stage", stage, e[1:0]);
        check("drop time", ($time - t_up) < 66 * MS_NS, 1);
      end
      if (e[2])
        check("raise time", ($time - t_dn) < 20 * MS_NS, 1);
    end
  end

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial
  begin
    seed = 45244;
    sys_rst = 1'b1;
    small_variant = 1'b1;
    internal_fault = 1'b0;
    error_cancel = 1'b0;
    volt_on = 1'b0;
    stuck = 1'b0;
    delay = 16'h0020;
    cyc(8);
    sys_rst <= 1'b0;
    cyc(300);
    #1;
    check("idle", {vm, rdy, run, stage}, 5'h18);
    $display("Test idle finished");
    for (int s = 0; s < 3; s++)
    begin
      exp_q.push_back({1'b0, 2'(s)});
      exp_q.push_back(3'h7);
    end
    cyc(1);
    // Relay answer stays well under one scaled ms
    delay <= 16'(20 + ($random(seed) & 32'h3F));
    volt_on <= 1'b1;
    wait_hi(run, 4000);
    check("run", {rdy, ack, vm, exp_q.size() == 0}, 4'hD);
    $display("Test self-test finished");
    cyc(1);
    volt_on <= 1'b0;
    wait_hi(esh, 400);
    check("stop flags", {cef, xsf, run}, 3'h6);
    pulse_cancel();
    check("estop_shown", esh, 1);
    cyc(1);
    delay <= 16'(20 + ($random(seed) & 32'h3F));
    volt_on <= 1'b1;
    cyc(300);
    pulse_cancel();
    check("resumed", {esh, run}, 2'h1);
    $display("Test external stop finished");
    exp_q.push_back(3'h3);
    cyc(1);
    internal_fault <= 1'b1;
    cyc(1);
    internal_fault <= 1'b0;
    wait_hi(halt, 100);
    pulse_cancel();
    check("fault", {ffl, halt, rdy}, 3'h6);
    $display("Test fault finished");
    cyc(1);
    sys_rst <= 1'b1;
    small_variant <= 1'b0;
    stuck <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(1);
    #1;
    check("restart", {ffl, halt, stage}, 4'h0);
    exp_q.push_back(3'h0);
    cyc(1);
    volt_on <= 1'b1;
    wait_hi(sdef, 13000);
    check("limit", ($time - t_fall) > 113 * MS_NS, 1);
    check("limit", ($time - t_fall) < 116 * MS_NS, 1);
    check("defective", {halt, rdy}, 2'h2);
    check("notes left", exp_q.size(), 0);
    $display("Test stuck relay finished");
    give_verdict();
  end
endmodule // estop_ready_self_test_tb
